// File: design/pwc_top.sv
// Functional notes
// RULE1: Count readable only; writes to it ignored
// RULE2: Count clears on reset, compare write, changes
// RULE3: Compare register 8 bits, read/write, resets zero
// RULE4: Compare zero flags every prescaler tick
// RULE5: Any compare write clears prescaler and count
// RULE6: Reset: stopped, compare zero, off, slow source
// RULE7: Divider code zero stops; nonzero starts prescaler
// RULE8: Source code picks slow, external, internal clock
// RULE9: New source value clears prescaler and count
// RULE10: New divider value clears prescaler and count
// RULE11: Ratio from divider code and source low bit
// RULE12: Source low bit one gives long ratios
// RULE13: Count up to compare, then wrap to zero
// RULE14: Flag sets on each wrap to zero
// RULE15: Interrupt when flag and enable both set
// RULE16: Writing one clears flag and interrupt
// RULE17: Control layout: flag, source, enable, divider
// RULE18: Binary and decimal divide ratio table
// RULE19: Debug halt freezes counting, resumes after
// RULE20: Flag sticky until cleared; source clock synchronised
//
// Chosen here: the address map and the APB register port.
`timescale 1ns/10ps
`default_nettype none
module pwc_top (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [pwc_pkg::APB_AW-1:0] paddr_i,
	input wire logic [pwc_pkg::APB_DW-1:0] pwdata_i,
	output logic [pwc_pkg::APB_DW-1:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic low_power_osc_clock_i,
	input wire logic external_ref_clock_i,
	input wire logic internal_ref_clock_i,
	input wire logic dbg_halt_i,
	output logic irq_o
);
	typedef struct packed {
		pwc_pkg::pwc_run_t run;
		logic flag;
		logic ie;
		logic [1:0] src;
		logic [3:0] div;
		logic [7:0] mod;
		logic [7:0] cnt;
		logic src_d;
		logic [pwc_pkg::APB_DW-1:0] prdata;
		logic pslverr;
	} pwc_state_t;

	pwc_state_t cur_ff;
	pwc_state_t nxt_state;

	logic src_raw;
	logic src_sync;
	logic src_edge;
	logic ps_tick;
	logic ps_clear;
	logic wr_en;
	logic rd_setup;
	logic wr_sc;
	logic wr_cnt;
	logic wr_mod;
	logic [1:0] wr_src;
	logic [3:0] wr_div;
	logic flag_set;
	logic flag_clr;
	logic [7:0] sc_view;

	// Source mux ahead of the synchroniser; a source change clears the prescaler in the write cycle,
	// before the switched input reaches the edge detector, so a switch glitch can still count one edge
	always_comb begin
		if (cur_ff.src == pwc_pkg::SRC_LPO) begin
			src_raw = low_power_osc_clock_i; // RULE8
		end else if (cur_ff.src == pwc_pkg::SRC_EXT) begin
			src_raw = external_ref_clock_i; // RULE8
		end else begin
			src_raw = internal_ref_clock_i; // RULE8
		end
	end

	pwc_sync u_sync (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.async_i(src_raw),
		.sync_o(src_sync)
	);

	assign src_edge = src_sync && !cur_ff.src_d; // RULE20

	// APB decode; writes land in the access phase, reads are
	// captured in the setup phase so prdata comes from a flop
	assign wr_en = psel_i && penable_i && pwrite_i;
	assign rd_setup = psel_i && !penable_i && !pwrite_i;
	assign wr_sc = wr_en && pwc_pkg::pwc_hit(paddr_i, pwc_pkg::OFS_SC);
	assign wr_cnt = wr_en && pwc_pkg::pwc_hit(paddr_i, pwc_pkg::OFS_CNT);
	assign wr_mod = wr_en && pwc_pkg::pwc_hit(paddr_i, pwc_pkg::OFS_MOD);
	assign wr_src = pwdata_i[pwc_pkg::SC_SRC_HI:pwc_pkg::SC_SRC_LO];
	assign wr_div = pwdata_i[pwc_pkg::SC_DIV_HI:pwc_pkg::SC_DIV_LO];

	// Any compare write, or a real change of source or divider, restarts the chain
	assign ps_clear = wr_mod // RULE5
		|| (wr_sc && wr_src != cur_ff.src) // RULE9
		|| (wr_sc && wr_div != cur_ff.div); // RULE10

	pwc_prescaler u_prescaler (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.clear_i(ps_clear),
		.run_i(cur_ff.run == pwc_pkg::RUN_ACTIVE),
		.edge_i(src_edge),
		.ratio_i(pwc_pkg::pwc_ratio(cur_ff.div, cur_ff.src[0])), // RULE11 RULE12 RULE18
		.tick_o(ps_tick)
	);

	assign flag_set = ps_tick && !ps_clear && (cur_ff.cnt == cur_ff.mod); // RULE14 RULE4
	assign flag_clr = wr_sc && pwdata_i[pwc_pkg::SC_FLAG_BIT]; // RULE16

	assign sc_view = {cur_ff.flag, cur_ff.src, cur_ff.ie, cur_ff.div}; // RULE17

	always_comb begin
		nxt_state = cur_ff;
		nxt_state.src_d = src_sync;

		if (wr_sc) begin
			nxt_state.src = wr_src;
			nxt_state.ie = pwdata_i[pwc_pkg::SC_IE_BIT];
			nxt_state.div = wr_div;
		end
		if (wr_mod) begin
			nxt_state.mod = pwdata_i[7:0]; // RULE3
		end

		case (cur_ff.run)
			pwc_pkg::RUN_OFF: begin
				if (dbg_halt_i) begin
					nxt_state.run = pwc_pkg::RUN_HALT;
				end else if (nxt_state.div != pwc_pkg::DIV_OFF) begin
					nxt_state.run = pwc_pkg::RUN_ACTIVE; // RULE7
				end
			end
			pwc_pkg::RUN_ACTIVE: begin
				if (dbg_halt_i) begin
					nxt_state.run = pwc_pkg::RUN_HALT; // RULE19
				end else if (nxt_state.div == pwc_pkg::DIV_OFF) begin
					nxt_state.run = pwc_pkg::RUN_OFF; // RULE7
				end
			end
			pwc_pkg::RUN_HALT: begin
				if (!dbg_halt_i) begin
					nxt_state.run = (nxt_state.div == pwc_pkg::DIV_OFF) ? pwc_pkg::RUN_OFF : pwc_pkg::RUN_ACTIVE;
				end
			end
			default: begin
				nxt_state.run = pwc_pkg::RUN_OFF;
			end
		endcase

		// Count register writes fall through untouched
		if (ps_clear) begin
			nxt_state.cnt = pwc_pkg::CNT_RST; // RULE2
		end else if (ps_tick) begin
			if (cur_ff.cnt == cur_ff.mod) begin
				nxt_state.cnt = pwc_pkg::CNT_RST; // RULE13
			end else begin
				nxt_state.cnt = cur_ff.cnt + 8'h01; // RULE13
			end
		end

		// Set beats a simultaneous clear so no wrap is lost
		if (flag_set) begin
			nxt_state.flag = 1'b1; // RULE14 RULE20
		end else if (flag_clr) begin
			nxt_state.flag = 1'b0; // RULE16
		end

		nxt_state.pslverr = 1'b0;
		if (psel_i && !penable_i) begin
			nxt_state.prdata = '0;
			if (pwc_pkg::pwc_hit(paddr_i, pwc_pkg::OFS_SC)) begin
				nxt_state.prdata[7:0] = sc_view;
			end else if (pwc_pkg::pwc_hit(paddr_i, pwc_pkg::OFS_CNT)) begin
				nxt_state.prdata[7:0] = cur_ff.cnt; // RULE1
			end else if (pwc_pkg::pwc_hit(paddr_i, pwc_pkg::OFS_MOD)) begin
				nxt_state.prdata[7:0] = cur_ff.mod;
			end else begin
				nxt_state.pslverr = 1'b1;
			end
			if (!rd_setup) begin
				nxt_state.prdata = '0;
			end
		end else if (!psel_i) begin
			nxt_state.prdata = '0;
		end else begin
			nxt_state.pslverr = cur_ff.pslverr;
		end
	end

	// Everything clears, including selection fields
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cur_ff.run <= pwc_pkg::RUN_OFF; // RULE6
			cur_ff.flag <= 1'b0;
			cur_ff.ie <= 1'b0;
			cur_ff.src <= pwc_pkg::SRC_LPO; // RULE6
			cur_ff.div <= pwc_pkg::DIV_OFF; // RULE6
			cur_ff.mod <= pwc_pkg::MOD_RST; // RULE6
			cur_ff.cnt <= pwc_pkg::CNT_RST; // RULE6
			cur_ff.src_d <= 1'b0;
			cur_ff.prdata <= '0;
			cur_ff.pslverr <= 1'b0;
		end else begin
			cur_ff <= nxt_state;
		end
	end

	assign prdata_o = cur_ff.prdata;
	assign pready_o = 1'b1;
	assign pslverr_o = cur_ff.pslverr && psel_i && penable_i;
	assign irq_o = cur_ff.flag && cur_ff.ie; // RULE15

	a_cnt_readonly: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE1
		(wr_cnt && !ps_tick) |=> (cur_ff.cnt == $past(cur_ff.cnt)))
		else $error("count changed by a write to the count register");

	a_mod_write_clear: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE5
		wr_mod |=> (cur_ff.cnt == pwc_pkg::CNT_RST) ##1 (cur_ff.cnt == pwc_pkg::CNT_RST))
		else $error("compare write did not clear the count");

	a_src_change_clear: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE9
		(wr_sc && wr_src != cur_ff.src) |=> (cur_ff.cnt == pwc_pkg::CNT_RST))
		else $error("source change did not clear the count");

	a_off_no_count: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE7
		(cur_ff.div == pwc_pkg::DIV_OFF && !wr_en)[*3] |-> $stable(cur_ff.cnt))
		else $error("count moved with divider off");

	a_wrap_sets_flag: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE14
		(ps_tick && !ps_clear && cur_ff.cnt == cur_ff.mod)
			|=> (cur_ff.flag && cur_ff.cnt == pwc_pkg::CNT_RST))
		else $error("wrap did not set the flag and zero the count");

	a_flag_sticky: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE20
		(cur_ff.flag && !flag_clr) |=> cur_ff.flag)
		else $error("flag dropped without a clear");

	a_flag_w1c: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE16
		(flag_clr && !flag_set) |=> (!cur_ff.flag && !irq_o))
		else $error("writing one did not clear the flag");

	a_irq_follows: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE15
		($rose(cur_ff.flag) && cur_ff.ie) |-> irq_o ##1 (irq_o || !cur_ff.flag || !cur_ff.ie))
		else $error("interrupt missing while flag and enable set");

	a_halt_freeze: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE19
		(dbg_halt_i && !wr_en)[*4] |-> $stable(cur_ff.cnt))
		else $error("count moved during debug halt");
endmodule
`default_nettype wire

// File: inc/pwc_pkg.sv
package pwc_pkg;

	localparam int APB_AW = 12;
	localparam int APB_DW = 32;
	localparam logic [APB_AW-1:0] OFS_SC = 12'h000;
	localparam logic [APB_AW-1:0] OFS_CNT = 12'h004;
	localparam logic [APB_AW-1:0] OFS_MOD = 12'h008;

	localparam int SC_FLAG_BIT = 7;
	localparam int SC_SRC_HI = 6;
	localparam int SC_SRC_LO = 5;
	localparam int SC_IE_BIT = 4;
	localparam int SC_DIV_HI = 3;
	localparam int SC_DIV_LO = 0;

	localparam logic [7:0] CNT_RST = 8'h00;
	localparam logic [7:0] MOD_RST = 8'h00;
	localparam logic [1:0] SRC_LPO = 2'h0;
	localparam logic [1:0] SRC_EXT = 2'h1;
	localparam logic [3:0] DIV_OFF = 4'h0;

	localparam int PS_W = 18;
	localparam logic [PS_W-1:0] PS_ZERO = 18'h00000;
	localparam logic [PS_W-1:0] PS_ONE = 18'h00001;

	// Divide ratios, index is the divider code; code 0 is off
	localparam logic [PS_W-1:0] DIV_TAB_LO [16] = '{
		18'h00001, 18'h00008, 18'h00020, 18'h00040, 18'h00080, 18'h00100, 18'h00200, 18'h00400,
		18'h00001, 18'h00002, 18'h00004, 18'h0000a, 18'h00010, 18'h00064, 18'h001f4, 18'h003e8};
	localparam logic [PS_W-1:0] DIV_TAB_HI [16] = '{
		18'h00001, 18'h00400, 18'h00800, 18'h01000, 18'h02000, 18'h04000, 18'h08000, 18'h10000,
		18'h003e8, 18'h007d0, 18'h01388, 18'h02710, 18'h04e20, 18'h0c350, 18'h186a0, 18'h30d40};

	typedef enum logic [1:0] {
		RUN_OFF = 2'b00,
		RUN_ACTIVE = 2'b01,
		RUN_HALT = 2'b10
	} pwc_run_t;

	function automatic logic [PS_W-1:0] pwc_ratio(input logic [3:0] div, input logic src_lsb);
		pwc_ratio = src_lsb ? DIV_TAB_HI[div] : DIV_TAB_LO[div];
	endfunction

	function automatic logic pwc_hit(input logic [APB_AW-1:0] addr, input logic [APB_AW-1:0] ofs);
		pwc_hit = (addr == ofs);
	endfunction

endpackage

// File: design/pwc_sync.sv
`timescale 1ns/10ps
`default_nettype none
module pwc_sync (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic async_i,
	output logic sync_o
);
	typedef struct packed {
		logic meta;
		logic stable;
	} pwc_sync_t;

	pwc_sync_t cur_ff;
	pwc_sync_t nxt_state;

	always_comb begin
		nxt_state.meta = async_i;
		nxt_state.stable = cur_ff.meta;
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_state;
		end
	end

	assign sync_o = cur_ff.stable;
endmodule
`default_nettype wire

// File: design/pwc_prescaler.sv
`timescale 1ns/10ps
`default_nettype none
module pwc_prescaler (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic clear_i,
	input wire logic run_i,
	input wire logic edge_i,
	input wire logic [pwc_pkg::PS_W-1:0] ratio_i,
	output logic tick_o
);
	typedef struct packed {
		logic [pwc_pkg::PS_W-1:0] cnt;
		logic tick;
	} pwc_ps_t;

	pwc_ps_t cur_ff;
	pwc_ps_t nxt_state;

	always_comb begin
		nxt_state = cur_ff;
		nxt_state.tick = 1'b0;
		if (clear_i) begin
			nxt_state.cnt = pwc_pkg::PS_ZERO;
		end else if (run_i && edge_i) begin
			if (cur_ff.cnt >= ratio_i - pwc_pkg::PS_ONE) begin
				nxt_state.cnt = pwc_pkg::PS_ZERO;
				nxt_state.tick = 1'b1;
			end else begin
				nxt_state.cnt = cur_ff.cnt + pwc_pkg::PS_ONE;
			end
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_state;
		end
	end

	assign tick_o = cur_ff.tick;
endmodule
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [pwc_pkg::APB_AW-1:0] paddr = 12'h000;
	logic [pwc_pkg::APB_DW-1:0] pwdata = 32'h00000000;
	logic [pwc_pkg::APB_DW-1:0] prdata;
	logic pready;
	logic pslverr;
	logic [2:0] src_clk = 3'h0;
	logic dbg_halt = 1'b0;
	logic irq;
	logic err;
	int fail_count = 0;
	int n_tests = 0;

	pwc_top dut (.ref_clk_i(ref_clk), .rst_i(rst), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.low_power_osc_clock_i(src_clk[0]), .external_ref_clock_i(src_clk[1]),
		.internal_ref_clock_i(src_clk[2]), .dbg_halt_i(dbg_halt), .irq_o(irq));

	initial begin
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic stop_test();
		$display("mismatches %0d of %0d comparisons", fail_count, n_tests);
		if (fail_count == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Waits on pready rather than assuming the zero-wait answer
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
		int n;
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 32);
		if (pready !== 1'b1) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, pready, 1'b1);
			stop_test();
		end
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [31:0] r;
		apb(1'b1, a, {24'h000000, d}, r);
	endtask

	task automatic rd(input logic [11:0] a, input logic [7:0] exp);
		logic [31:0] r;
		apb(1'b0, a, 32'h00000000, r);
		chk(r, {24'h000000, exp});
	endtask

	// Pin pulses are kept far below half the system clock rate
	task automatic pulses(input int n, input logic [2:0] m);
		repeat (n) begin
			@(posedge ref_clk);
			src_clk <= m;
			repeat (4) @(posedge ref_clk);
			src_clk <= 3'h0;
			repeat (3) @(posedge ref_clk);
		end
		repeat (6) @(posedge ref_clk);
	endtask

	task automatic t_reset();
		rd(pwc_pkg::OFS_SC, 8'h00);
		rd(pwc_pkg::OFS_CNT, 8'h00);
		rd(pwc_pkg::OFS_MOD, 8'h00);
		chk_bit(irq, 1'b0);
		pulses(3, 3'h7);
		rd(pwc_pkg::OFS_CNT, 8'h00);
	endtask

	task automatic t_access();
		logic [31:0] r;
		apb(1'b0, 12'h00c, 32'h00000000, r);
		chk(r, 32'h00000000);
		chk_bit(err, 1'b1);
		wr(pwc_pkg::OFS_MOD, 8'hff);
		rd(pwc_pkg::OFS_MOD, 8'hff);
		wr(pwc_pkg::OFS_SC, 8'h08);
		pulses(3, 3'h1);
		rd(pwc_pkg::OFS_CNT, 8'h03);
		wr(pwc_pkg::OFS_CNT, 8'h55);
		rd(pwc_pkg::OFS_CNT, 8'h03);
		wr(pwc_pkg::OFS_SC, 8'h08);
		rd(pwc_pkg::OFS_CNT, 8'h03);
		wr(pwc_pkg::OFS_MOD, 8'hff);
		rd(pwc_pkg::OFS_CNT, 8'h00);
	endtask

	task automatic t_sources();
		pulses(2, 3'h1);
		wr(pwc_pkg::OFS_SC, 8'h28);
		rd(pwc_pkg::OFS_CNT, 8'h00);
		pulses(2, 3'h5);
		rd(pwc_pkg::OFS_CNT, 8'h00);
		// External source runs the long table here, so a full ratio is needed
		pulses(999, 3'h2);
		rd(pwc_pkg::OFS_CNT, 8'h00);
		pulses(1, 3'h2);
		rd(pwc_pkg::OFS_CNT, 8'h01);
		wr(pwc_pkg::OFS_SC, 8'h48);
		rd(pwc_pkg::OFS_CNT, 8'h00);
		pulses(3, 3'h4);
		rd(pwc_pkg::OFS_CNT, 8'h03);
		wr(pwc_pkg::OFS_SC, 8'h68);
		pulses(999, 3'h4);
		rd(pwc_pkg::OFS_CNT, 8'h00);
		pulses(1, 3'h4);
		rd(pwc_pkg::OFS_CNT, 8'h01);
	endtask

	task automatic t_ratios();
		wr(pwc_pkg::OFS_SC, 8'h01);
		rd(pwc_pkg::OFS_CNT, 8'h00);
		pulses(15, 3'h1);
		rd(pwc_pkg::OFS_CNT, 8'h01);
		pulses(1, 3'h1);
		rd(pwc_pkg::OFS_CNT, 8'h02);
		wr(pwc_pkg::OFS_SC, 8'h0b);
		pulses(19, 3'h1);
		rd(pwc_pkg::OFS_CNT, 8'h01);
		pulses(1, 3'h1);
		rd(pwc_pkg::OFS_CNT, 8'h02);
	endtask

	task automatic t_wrap();
		wr(pwc_pkg::OFS_MOD, 8'h02);
		wr(pwc_pkg::OFS_SC, 8'h18);
		pulses(2, 3'h1);
		rd(pwc_pkg::OFS_CNT, 8'h02);
		rd(pwc_pkg::OFS_SC, 8'h18);
		chk_bit(irq, 1'b0);
		pulses(1, 3'h1);
		rd(pwc_pkg::OFS_CNT, 8'h00);
		rd(pwc_pkg::OFS_SC, 8'h98);
		chk_bit(irq, 1'b1);
		pulses(4, 3'h1);
		rd(pwc_pkg::OFS_CNT, 8'h01);
		chk_bit(irq, 1'b1);
		wr(pwc_pkg::OFS_SC, 8'h18);
		rd(pwc_pkg::OFS_SC, 8'h98);
		wr(pwc_pkg::OFS_SC, 8'h98);
		rd(pwc_pkg::OFS_SC, 8'h18);
		chk_bit(irq, 1'b0);
		rd(pwc_pkg::OFS_CNT, 8'h01);
		pulses(2, 3'h1);
		wr(pwc_pkg::OFS_SC, 8'h88);
		rd(pwc_pkg::OFS_SC, 8'h08);
		chk_bit(irq, 1'b0);
	endtask

	task automatic t_zero_cmp();
		wr(pwc_pkg::OFS_MOD, 8'h00);
		pulses(1, 3'h1);
		rd(pwc_pkg::OFS_SC, 8'h88);
		rd(pwc_pkg::OFS_CNT, 8'h00);
		wr(pwc_pkg::OFS_SC, 8'h88);
		rd(pwc_pkg::OFS_SC, 8'h08);
		pulses(1, 3'h1);
		rd(pwc_pkg::OFS_SC, 8'h88);
	endtask

	// Edges seen while halted are lost, so the count holds exactly
	task automatic t_halt();
		wr(pwc_pkg::OFS_MOD, 8'hff);
		pulses(2, 3'h1);
		@(posedge ref_clk);
		dbg_halt <= 1'b1;
		repeat (2) @(posedge ref_clk);
		pulses(3, 3'h1);
		rd(pwc_pkg::OFS_CNT, 8'h02);
		dbg_halt <= 1'b0;
		pulses(1, 3'h1);
		rd(pwc_pkg::OFS_CNT, 8'h03);
	endtask

	initial begin
		#800000;
		fail_count++;
		stop_test();
	end

	initial begin
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		t_reset();
		t_access();
		t_sources();
		t_ratios();
		t_wrap();
		t_zero_cmp();
		t_halt();
		stop_test();
	end
endmodule
`default_nettype wire
